/* File: pkg/ops_pkg.sv */
// constants for the priority shutdown block: register map, reset values, timing
// assumes a 40 MHz system clock and byte-wide register access
package ops_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam logic [7:0] REMAP_ADDR = 8'h26;
  localparam logic [7:0] PRIO12_ADDR = 8'h27;
  localparam logic [7:0] PRIO34_ADDR = 8'h28;
  localparam logic [7:0] REMAP_RESET = 8'he4;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [7:0] PRIO_RW_MASK = 8'h77;
  localparam int unsigned ODD_FIELD_LSB = 0;
  localparam int unsigned EVEN_FIELD_LSB = 4;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned NUM_CH = 4;
  // low gap before a pulse at least this long means a one bit
  localparam int unsigned GAP_ONE_NS = 2000;
  // low gap at least this long starts a new code
  localparam int unsigned FRAME_GAP_NS = 10000;
  localparam int unsigned GAP_ONE_CYC = (GAP_ONE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned FRAME_GAP_CYC = (FRAME_GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned GAP_CNT_W = 10;
  localparam logic [GAP_CNT_W-1:0] GAP_ONE_CNT = GAP_CNT_W'(GAP_ONE_CYC);
  localparam logic [GAP_CNT_W-1:0] FRAME_GAP_CNT = GAP_CNT_W'(FRAME_GAP_CYC);
  typedef enum logic [1:0] {
    OPS_RX_FIRST = 2'b00,
    OPS_RX_SECOND = 2'b01,
    OPS_RX_THIRD = 2'b11,
    OPS_RX_LAST = 2'b10
  } ops_rx_state_t;
endpackage

/* File: rtl/ops_code_rx.sv */
// serial shutdown code receiver: start pulse, then three data pulses, msb first
// each data bit is carried by the low gap before its pulse
// assumes the pin is asynchronous; it is synchronised here
`timescale 1ns/1ps
`default_nettype none
module ops_code_rx
(
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic pin_in, // raw shutdown pin
  output logic rise_pulse, // rising edge seen, one cycle
  output logic code_valid, // full code taken, one cycle
  output logic [ops_pkg::CODE_W-1:0] code // received code, msb first
);
  logic sync1_reg, sync2_reg, prev_reg;
  logic sync1_next, sync2_next, prev_next;
  logic [ops_pkg::GAP_CNT_W-1:0] gap_reg, gap_next;
  logic [1:0] bits_reg, bits_next;
  ops_pkg::ops_rx_state_t state_reg, state_next;
  logic rise, bit_val;

  always_comb
  begin
    sync1_next = pin_in;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    rise = sync2_reg & ~prev_reg;
    bit_val = (gap_reg >= ops_pkg::GAP_ONE_CNT);
    gap_next = gap_reg;
    bits_next = bits_reg;
    state_next = state_reg;
    code_valid = 1'b0;
    code = {bits_reg, bit_val};
    if (sync2_reg)
    begin
      gap_next = '0;
    end
    else if (gap_reg != '1)
    begin
      gap_next = gap_reg + 1'b1;
    end
    // a long idle gap always restarts framing, so a lost pulse costs one code only
    if (rise)
    begin
      if (gap_reg >= ops_pkg::FRAME_GAP_CNT)
      begin
        bits_next = '0;
        state_next = ops_pkg::OPS_RX_SECOND;
      end
      else
      begin
        case (state_reg)
          ops_pkg::OPS_RX_SECOND:
          begin
            bits_next = {1'b0, bit_val};
            state_next = ops_pkg::OPS_RX_THIRD;
          end
          ops_pkg::OPS_RX_THIRD:
          begin
            bits_next = {bits_reg[0], bit_val};
            state_next = ops_pkg::OPS_RX_LAST;
          end
          ops_pkg::OPS_RX_LAST:
          begin
            // acted on at the rising edge, well before the last pulse ends
            code_valid = 1'b1;
            state_next = ops_pkg::OPS_RX_FIRST;
          end
          default:
          begin
            // short gap with no frame open: wait for the next long idle
            state_next = ops_pkg::OPS_RX_FIRST;
          end
        endcase
      end
    end
    else if (gap_reg >= ops_pkg::FRAME_GAP_CNT)
    begin
      state_next = ops_pkg::OPS_RX_FIRST;
    end
    rise_pulse = rise;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      gap_reg <= '1;
      bits_reg <= '0;
      state_reg <= ops_pkg::OPS_RX_FIRST;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      gap_reg <= gap_next;
      bits_reg <= bits_next;
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ops_priority_shutdown.sv */
// per-channel priority shutdown for channels 1 to 4, priority and re-mapping registers
// assumes a byte register port from the serial-bus engine and an asynchronous shutdown pin
`timescale 1ns/1ps
`default_nettype none
// How it works
// - the re-mapping register is reloaded only by power-on reset, never by the pin reset.
// - the 3-bit priority fields act only while three-bit priority mode is selected.
// - a received serial shutdown code is judged against the per-channel priority fields.
// - a priority turn-off clears channel bits like the reset command but keeps cool-down.
// - every channel whose priority value is at least the code is turned off.
// - a channel whose priority value is below the code is left alone.
// - value zero falls only to code zero, seven to any code, five to all but six and seven.
// - odd channel field in bits 2..0, even in bits 6..4, bits 7 and 3 unused.
// - no memory of past codes; each code acts at once, before its last pulse ends.
// - channels sharing a priority value are turned off together.
module ops_priority_shutdown
(
  input wire logic clk, // 40 MHz system clock
  input wire logic sys_rst, // pin reset, synchronous
  input wire logic por_rst, // power-on reset, synchronous
  input wire logic serial_fast_shutdown_input, // raw shutdown pin
  input wire logic three_bit_priority_select, // general mask mode bit
  input wire logic group_all_off, // all channels of the group in off mode
  input wire logic [ops_pkg::NUM_CH-1:0] channel_reset_cmd, // reset command, one pulse/ch
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  output logic [7:0] remap_value, // current re-mapping setting
  output logic [ops_pkg::NUM_CH-1:0] clear_channel_bits, // clear channel state, pulse
  output logic [ops_pkg::NUM_CH-1:0] cancel_cooldown, // stop cool-down timer, pulse
  output logic one_bit_shutdown // single-bit mode shutdown, pulse
);
  logic [7:0] prio12_reg;
  logic [7:0] prio12_next;
  logic [7:0] prio34_reg;
  logic [7:0] prio34_next;
  logic [7:0] remap_reg;
  logic [7:0] remap_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [ops_pkg::NUM_CH-1:0] clear_reg;
  logic [ops_pkg::NUM_CH-1:0] clear_next;
  logic [ops_pkg::NUM_CH-1:0] cancel_reg;
  logic [ops_pkg::NUM_CH-1:0] cancel_next;
  logic onebit_reg;
  logic onebit_next;
  logic rx_rise;
  logic rx_valid;
  logic [ops_pkg::CODE_W-1:0] rx_code;
  logic code_act;
  logic [ops_pkg::NUM_CH-1:0] prio_hit;
  logic remap_dup;
  logic remap_ok;
  logic wr_prio12;
  logic wr_prio34;
  logic wr_remap;

  ops_code_rx u_rx
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(serial_fast_shutdown_input),
    .rise_pulse(rx_rise),
    .code_valid(rx_valid),
    .code(rx_code)
  );

  // the code only counts in three-bit mode; the fields stay live either way
  assign code_act = three_bit_priority_select && rx_valid;

  // one comparator per channel, all fire in the same cycle
  for (genvar ch = 0; ch < ops_pkg::NUM_CH; ch++)
  begin : g_cmp
    logic [ops_pkg::CODE_W-1:0] field;
    logic [7:0] src;
    assign src = (ch < 2) ? prio12_reg : prio34_reg;
    assign field = (ch % 2 == 0) ? src[ops_pkg::ODD_FIELD_LSB +: ops_pkg::CODE_W]
      : src[ops_pkg::EVEN_FIELD_LSB +: ops_pkg::CODE_W];
    // greater or equal: a code hits its own value and every lower priority
    assign prio_hit[ch] = code_act && (field >= rx_code);
  end

  // write decode; unmapped addresses fall through and are dropped
  always_comb
  begin
    wr_prio12 = 1'b0;
    wr_prio34 = 1'b0;
    wr_remap = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        ops_pkg::PRIO12_ADDR: wr_prio12 = 1'b1;
        ops_pkg::PRIO34_ADDR: wr_prio34 = 1'b1;
        ops_pkg::REMAP_ADDR: wr_remap = 1'b1;
        default: wr_remap = 1'b0;
      endcase
    end
  end

  // duplicate physical channel codes are refused whole
  always_comb
  begin
    remap_dup = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      for (int j = i + 1; j < 4; j++)
      begin
        if (reg_wdata[2*i +: 2] == reg_wdata[2*j +: 2])
        begin
          remap_dup = 1'b1;
        end
      end
    end
  end

  // a re-map is taken only with the whole group off and no physical channel used twice
  assign remap_ok = group_all_off && !remap_dup;

  always_comb
  begin
    prio12_next = prio12_reg;
    prio34_next = prio34_reg;
    remap_next = remap_reg;
    // unused bits 7 and 3 are never stored, so they always read back zero
    if (wr_prio12)
    begin
      prio12_next = reg_wdata & ops_pkg::PRIO_RW_MASK;
    end
    if (wr_prio34)
    begin
      prio34_next = reg_wdata & ops_pkg::PRIO_RW_MASK;
    end
    if (wr_remap && remap_ok)
    begin
      remap_next = reg_wdata;
    end
  end

  // read data holds until the next read strobe
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd)
    begin
      case (reg_addr)
        ops_pkg::PRIO12_ADDR: rdata_next = prio12_reg;
        ops_pkg::PRIO34_ADDR: rdata_next = prio34_reg;
        ops_pkg::REMAP_ADDR: rdata_next = remap_reg;
        // unmapped reads give zero rather than stale data
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // shutdown clears like a channel reset, but only the reset command stops cool-down
  always_comb
  begin
    // a command and a code on one channel in one cycle give a single clear
    clear_next = prio_hit | channel_reset_cmd;
    cancel_next = channel_reset_cmd;
    onebit_next = rx_rise && !three_bit_priority_select;
  end

  // pin reset leaves the re-mapping alone, user mappings survive it
  always_ff @(posedge clk)
  begin
    if (por_rst)
    begin
      remap_reg <= ops_pkg::REMAP_RESET;
    end
    else
    begin
      remap_reg <= remap_next;
    end
  end

  // priority fields follow either reset, unlike the re-mapping
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
    begin
      prio12_reg <= ops_pkg::PRIO_RESET;
      prio34_reg <= ops_pkg::PRIO_RESET;
      rdata_reg <= 8'h00;
    end
    else
    begin
      prio12_reg <= prio12_next;
      prio34_reg <= prio34_next;
      rdata_reg <= rdata_next;
    end
  end

  // single-cycle strobes; the channel logic downstream does the clearing
  always_ff @(posedge clk)
  begin
    if (sys_rst || por_rst)
    begin
      clear_reg <= '0;
      cancel_reg <= '0;
      onebit_reg <= 1'b0;
    end
    else
    begin
      clear_reg <= clear_next;
      cancel_reg <= cancel_next;
      onebit_reg <= onebit_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign remap_value = remap_reg;
  assign clear_channel_bits = clear_reg;
  assign cancel_cooldown = cancel_reg;
  assign one_bit_shutdown = onebit_reg;
endmodule
`default_nettype wire

/* File: testbench/ops_assertions.sv */
// port checker for the priority shutdown block
// assumes one clock and both resets synchronous
`timescale 1ns/1ps
`default_nettype none
module ops_checker
(
  input wire logic clk, // clock
  input wire logic sys_rst, // pin reset
  input wire logic por_rst, // power-on reset
  input wire logic serial_fast_shutdown_input, // pin
  input wire logic three_bit_priority_select, // mode
  input wire logic group_all_off, // all off
  input wire logic [ops_pkg::NUM_CH-1:0] channel_reset_cmd, // reset cmd
  input wire logic [7:0] reg_addr, // address
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic [7:0] remap_value, // remap
  input wire logic [ops_pkg::NUM_CH-1:0] clear_channel_bits, // clear
  input wire logic [ops_pkg::NUM_CH-1:0] cancel_cooldown, // cancel
  input wire logic one_bit_shutdown // one-bit pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);
  property p_remap_kept;
    disable iff (por_rst) sys_rst |=> $stable(remap_value);
  endproperty
  a_remap_kept: assert property (p_remap_kept)
    else $error("remap changed by pin reset");
  property p_mode_gate;
    (clear_channel_bits & ~$past(channel_reset_cmd)) != 4'h0 |-> $past(three_bit_priority_select);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("code clear outside three-bit mode");
  property p_one_bit;
    $rose(serial_fast_shutdown_input) && !three_bit_priority_select |-> ##[2:6] one_bit_shutdown;
  endproperty
  a_one_bit: assert property (p_one_bit)
    else $error("no one-bit shutdown pulse");
  property p_cancel;
    cancel_cooldown == $past(channel_reset_cmd);
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("cool-down cancel not from reset command");
  property p_cmd_clear;
    channel_reset_cmd != 4'h0 |=> (clear_channel_bits & $past(channel_reset_cmd))
      == $past(channel_reset_cmd);
  endproperty
  a_cmd_clear: assert property (p_cmd_clear)
    else $error("reset command did not clear channel");
  property p_in_pulse;
    (clear_channel_bits & ~$past(channel_reset_cmd)) != 4'h0 |-> serial_fast_shutdown_input;
  endproperty
  a_in_pulse: assert property (p_in_pulse)
    else $error("code acted after its last pulse");
  property p_one_shot;
    (clear_channel_bits & ~$past(channel_reset_cmd)) != 4'h0
      |=> (clear_channel_bits & ~$past(channel_reset_cmd)) == 4'h0;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("code clear repeated");
  property p_rsv_bits;
    reg_rd && (reg_addr == ops_pkg::PRIO12_ADDR || reg_addr == ops_pkg::PRIO34_ADDR)
      |=> (reg_rdata & ~ops_pkg::PRIO_RW_MASK) == 8'h00;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits)
    else $error("unused priority bits read set");
endmodule
bind ops_priority_shutdown ops_checker u_chk (.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst),
  .serial_fast_shutdown_input(serial_fast_shutdown_input), .reg_wdata(reg_wdata),
  .three_bit_priority_select(three_bit_priority_select), .group_all_off(group_all_off),
  .channel_reset_cmd(channel_reset_cmd), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remap_value(remap_value),
  .clear_channel_bits(clear_channel_bits), .cancel_cooldown(cancel_cooldown),
  .one_bit_shutdown(one_bit_shutdown));
`default_nettype wire

/* File: testbench/ops_host_model.sv */
// host model sending serial shutdown codes
// assumes the receiver framing: long idle, then a start pulse and three data pulses
`timescale 1ns/1ps
`default_nettype none
module ops_host_model
(
  input wire logic clk, // system clock
  output logic pin // shutdown pin, low at idle
);
  initial pin = 1'b0;
  task automatic pulse(input int gap);
    repeat (gap) @(negedge clk);
    pin = 1'b1;
    // held well past the point where the device acts
    repeat (12) @(negedge clk);
    pin = 1'b0;
  endtask
  // long idle then a start pulse with no data, then the three code bits, msb first
  task automatic send_code(input logic [2:0] code);
    pulse(420);
    pulse(code[2] ? 100 : 20);
    pulse(code[1] ? 100 : 20);
    pulse(code[0] ? 100 : 20);
  endtask
endmodule
`default_nettype wire

/* File: testbench/ops_priority_shutdown_bench.sv */
// self-checking bench for the priority shutdown block
// assumes the host model owns the shutdown pin
`timescale 1ns/1ps
`default_nettype none
module ops_priority_shutdown_bench;
  logic clk, sys_rst, por_rst, pin, mode, all_off, reg_wr, reg_rd, one, seen_one;
  logic [3:0] cmd, clr, cc, seen_clr, seen_cc;
  logic [7:0] addr, wdata, rdata, remap;
  int miscompares = 0;
  int n_compared = 0;
  ops_priority_shutdown DUT (.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst),
    .serial_fast_shutdown_input(pin), .three_bit_priority_select(mode),
    .group_all_off(all_off), .channel_reset_cmd(cmd), .reg_addr(addr), .reg_wr(reg_wr),
    .reg_wdata(wdata), .reg_rd(reg_rd), .reg_rdata(rdata), .remap_value(remap),
    .clear_channel_bits(clr), .cancel_cooldown(cc), .one_bit_shutdown(one));
  ops_host_model HOST (.clk(clk), .pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    seen_clr <= seen_clr | clr;
    seen_cc <= seen_cc | cc;
    seen_one <= seen_one | one;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic send(input logic [2:0] code);
    seen_clr = 4'h0;
    seen_cc = 4'h0;
    seen_one = 1'b0;
    HOST.send_code(code);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_regs();
    reg_op(1'b0, ops_pkg::PRIO12_ADDR, 8'h00);
    check("prio12", rdata, ops_pkg::PRIO_RESET);
    reg_op(1'b1, ops_pkg::PRIO34_ADDR, 8'hff);
    reg_op(1'b0, ops_pkg::PRIO34_ADDR, 8'h00);
    check("prio34", rdata, 8'h77);
    reg_op(1'b0, 8'h40, 8'h00);
    check("unmapped", rdata, 8'h00);
  endtask
  task automatic t_cmd();
    @(negedge clk);
    cmd = 4'h5;
    @(negedge clk);
    cmd = 4'h0;
    check("cmd_clear", 8'(clr), 8'h05);
    check("cmd_cancel", 8'(cc), 8'h05);
  endtask
  task automatic t_codes();
    logic [2:0] prio [4] = '{3'h0, 3'h7, 3'h5, 3'h5};
    logic [3:0] exp;
    logic [2:0] code;
    reg_op(1'b1, ops_pkg::PRIO12_ADDR, 8'h70);
    reg_op(1'b1, ops_pkg::PRIO34_ADDR, 8'h55);
    mode = 1'b1;
    // every code once, then code 0 again: nothing carried over
    for (int c = 0; c < 9; c++)
    begin
      code = 3'(c % 8);
      foreach (prio[i]) exp[i] = (prio[i] >= code);
      send(code);
      check("code_clear", 8'(seen_clr), 8'(exp));
      check("code_cancel", 8'(seen_cc), 8'h00);
    end
  endtask
  task automatic t_mode_off();
    mode = 1'b0;
    send(3'h0);
    check("off_clear", 8'(seen_clr), 8'h00);
    check("off_pulse", 8'(seen_one), 8'h01);
    reg_op(1'b1, ops_pkg::PRIO12_ADDR, 8'h05);
    reg_op(1'b0, ops_pkg::PRIO12_ADDR, 8'h00);
    check("off_rw", rdata, 8'h05);
  endtask
  task automatic t_remap();
    all_off = 1'b1;
    reg_op(1'b1, ops_pkg::REMAP_ADDR, 8'h1b);
    all_off = 1'b0;
    sys_rst = 1'b1;
    @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check("remap_pin_rst", remap, 8'h1b);
    por_rst = 1'b1;
    @(negedge clk);
    por_rst = 1'b0;
    @(negedge clk);
    check("remap_por", remap, ops_pkg::REMAP_RESET);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    {sys_rst, por_rst, mode, all_off, reg_wr, reg_rd, seen_one} = 7'h60;
    {cmd, seen_clr, seen_cc, addr, wdata} = 28'h0000000;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    por_rst = 1'b0;
    t_regs();
    t_cmd();
    t_codes();
    t_mode_off();
    t_remap();
    finish_test();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
